// *** hdl/ecfg_pkg.sv ***
// Shared constants, encodings and carriers for the option configuration block
package ecfg_pkg;

	// ****************************************************************
	// Register map (byte addresses on the register bus)
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CFG = 8'h00; // Multi set point, remote enable, security
	localparam logic [7:0] ADDR_EVT = 8'h04; // Four event function selects
	localparam logic [7:0] ADDR_COMM = 8'h08; // Pending serial frame settings
	localparam logic [7:0] ADDR_ACT = 8'h0C; // Serial frame settings in force
	localparam logic [7:0] ADDR_STAT = 8'h10; // Live state

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CFG_MSP_LSB = 0; // Multi set point count, 2 bits
	localparam int CFG_RSP_BIT = 2; // Remote set point enable
	localparam int CFG_SEC_LSB = 4; // Security level, 2 bits
	localparam int EVT_PITCH = 4; // One select every nibble, 3 bits used
	localparam int COMM_STOP_BIT = 0; // 1 = two stop bits
	localparam int COMM_LEN_BIT = 1; // 1 = eight data bits
	localparam int COMM_PAR_LSB = 2; // Parity, 2 bits
	localparam int COMM_BAUD_LSB = 4; // Bit rate code, 3 bits
	localparam int COMM_UNIT_LSB = 8; // Unit number, 7 bits

	// ****************************************************************
	// Encodings and limits
	// ****************************************************************
	localparam logic [2:0] FN_NONE = 3'h0; // Input ignored
	localparam logic [2:0] FN_RUN_HALT = 3'h1; // On halts, off runs
	localparam logic [2:0] FN_REMOTE = 3'h2; // On selects remote operation
	localparam logic [2:0] FN_MANUAL = 3'h3; // On selects manual
	localparam logic [2:0] FN_SP_SRC = 3'h4; // On selects remote set point
	localparam logic [1:0] MSP_MAX = 2'h2; // Largest multi set point count
	localparam logic [1:0] PAR_ODD = 2'h2; // 0 none, 1 even, 2 odd
	localparam logic [2:0] BAUD_MAX = 3'h4; // 0..4 = 1.2, 2.4, 4.8, 9.6, 19.2 kbps
	localparam logic [6:0] UNIT_MAX = 7'h63; // Unit number ceiling
	localparam logic [1:0] SEC_OPT_MAX = 2'h1; // Highest security that allows option mode
	localparam logic [1:0] LEVEL_MAX = 2'h2; // Highest operating level

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [1:0] MSP_RST = 2'h2;
	localparam logic [1:0] SEC_RST = 2'h1;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ = 250; // System clock rate
	localparam int KEY_HOLD_MS = 1000; // Least key hold time
	localparam int KEY_HOLD_CYC = KEY_HOLD_MS * CLK_MHZ * 1000;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef logic [3:0][2:0] ecfg_sel_t; // Event selects, index 0 = input 1

	typedef struct packed {
		logic [6:0] unit; // Unit number
		logic [2:0] baud; // Bit rate code
		logic [1:0] parity; // Parity code
		logic len8; // Eight data bits
		logic stop2; // Two stop bits
	} ecfg_comm_s;

	localparam ecfg_comm_s COMM_RST = '{unit: 7'h00, baud: 3'h3, parity: 2'h1,
		len8: 1'b0, stop2: 1'b1};

	typedef struct packed {
		logic [1:0] sp_idx; // Selected set point
		logic halt; // Control halted
		logic remote; // Remote operation
		logic manual; // Manual output
		logic rsp_sel; // Remote set point in use
	} ecfg_evt_s;

endpackage

// *** hdl/ecfg_key_hold.sv ***
// Key hold timer: one pulse per press once the key has been held long enough
`timescale 1ns/100ps
`default_nettype none
module ecfg_key_hold
	import ecfg_pkg::*;
#(
	parameter int HOLD_CYC = KEY_HOLD_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_key,
	output logic o_held
);

	localparam int CW = $clog2(HOLD_CYC + 1);

	logic [CW-1:0] cnt_r; // Cycles held so far
	logic [CW-1:0] cnt_nxt;
	logic done_r; // Already fired for this press
	logic done_nxt;
	logic held_r; // Pulse register
	logic held_nxt;

	// ****************************************************************
	// Counting
	// ****************************************************************

	// A release restarts the count, so a bounce never adds up to a hold
	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = done_r;
		held_nxt = 1'b0;
		if (!i_key) begin
			cnt_nxt = '0;
			done_nxt = 1'b0;
		end else if (!done_r) begin
			if (cnt_r == CW'(HOLD_CYC - 1)) begin
				held_nxt = 1'b1;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + CW'(1);
			end
		end
	end

	// State registers
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= '0;
			done_r <= 1'b0;
			held_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			held_r <= held_nxt;
		end
	end

	assign o_held = held_r;

endmodule
`default_nettype wire

// *** hdl/ecfg_evt_map.sv ***
// Event input mapping onto set point selection and operating functions
`timescale 1ns/100ps
`default_nettype none
module ecfg_evt_map
	import ecfg_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_evt, // Event contacts, bit 0 = input 1
	input wire ecfg_sel_t i_sel, // Function of each input
	input wire logic [1:0] i_msp, // Multi set point count
	input wire logic i_two_units, // Both event units fitted
	input wire logic i_rsp_en, // Remote set point enable
	input wire logic i_comm_unit, // Communication unit fitted
	input wire logic i_block, // Menu or a configuration mode shown
	output ecfg_evt_s o_state
);

	ecfg_evt_s st_r; // Applied state
	ecfg_evt_s st_nxt;
	logic [2:0] used; // Inputs taken by set point selection

	// ****************************************************************
	// Mapping
	// ****************************************************************

	// Set point inputs come first; the rest follow their selects
	always_comb begin
		st_nxt = st_r;
		used = 3'h0;
		if (i_two_units) begin
			used = {1'b0, i_msp};
			if (i_msp == 2'h1) begin
				st_nxt.sp_idx = {1'b0, i_evt[0]};
			end else if (i_msp == MSP_MAX) begin
				st_nxt.sp_idx = i_evt[1:0];
			end else begin
				// Count zero: keep the chosen set point
				st_nxt.sp_idx = st_r.sp_idx;
			end
		end else begin
			used = 3'h2; // Inputs 1 and 2 are absent
		end
		for (int i = 0; i < 4; i++) begin
			if (3'(i) >= used) begin
				case (i_sel[i])
					FN_RUN_HALT: begin
						if (!i_block) st_nxt.halt = i_evt[i];
					end
					FN_REMOTE: begin
						if (i_comm_unit) st_nxt.remote = i_evt[i];
					end
					FN_MANUAL: begin
						if (!i_block) st_nxt.manual = i_evt[i];
					end
					FN_SP_SRC: begin
						if (!i_block && i_rsp_en) st_nxt.rsp_sel = i_evt[i];
					end
					default: begin
						// Not specified: input ignored
					end
				endcase
			end
		end
		// Without the enable the remote set point cannot stay selected
		if (!i_rsp_en) st_nxt.rsp_sel = 1'b0;
		// A pulled comm unit must not leave remote operation stuck on
		if (!i_comm_unit) st_nxt.remote = 1'b0;
	end

	// State register
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_state = st_r;

endmodule
`default_nettype wire

// *** hdl/ecfg_top.sv ***
// Option configuration top: register slave, mode entry and serial settings
// Functional notes
// - Count zero: events never change set point
// - Count one: set points 0-1; two: 0-3
// - Each input not taken by set point selection drives one selected function
// - One unit: only inputs 3, 4; defaults
// - Set point source needs enable; remote needs comm
// - Menu or config modes mask run, manual, source
// - Serial settings apply at power-up or at a level change in run mode with no other mode shown
// - Frame: stop, length, parity, rate, unit ranges
// - Option mode needs unit and security 0-1
// - Key held 1 s shows menu, again enters
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ecfg_top
	import ecfg_pkg::*;
#(
	parameter int HOLD_CYC = KEY_HOLD_CYC // Key hold time in cycles
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic [3:0] i_evt,
	input wire logic [1:0] i_evt_units,
	input wire logic i_comm_unit,
	input wire logic i_mode_key,
	input wire logic i_pick_option,
	input wire logic i_other_mode,
	input wire logic [1:0] i_level,
	output ecfg_comm_s o_comm,
	output ecfg_evt_s o_evt,
	output logic o_menu_shown,
	output logic o_option_mode
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	typedef enum logic [1:0] {MD_RUN, MD_MENU, MD_OPTION} ecfg_mode_e;

	ecfg_mode_e md_r; // Display mode
	ecfg_mode_e md_nxt;
	logic menu_r; // Menu shown
	logic menu_nxt;
	logic opt_r; // Option mode shown
	logic opt_nxt;
	logic [1:0] msp_r; // Multi set point count
	logic [1:0] msp_nxt;
	logic rsp_en_r; // Remote set point enable
	logic rsp_en_nxt;
	logic [1:0] sec_r; // Security level
	logic [1:0] sec_nxt;
	ecfg_sel_t sel_r; // Event function selects
	ecfg_sel_t sel_nxt;
	ecfg_comm_s pend_r; // Serial settings as written
	ecfg_comm_s pend_nxt;
	ecfg_comm_s act_r; // Serial settings in force
	ecfg_comm_s act_nxt;
	logic init_r; // First cycle after reset release
	logic [1:0] level_r; // Last seen operating level
	logic pready_r;
	logic pready_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic held; // Key hold pulse
	logic two_units; // Both event units fitted
	logic evt_fit; // Any event unit fitted
	logic opt_ok; // Option mode permitted
	logic wr_go; // Write takes effect this edge
	logic lvl_sw; // Operating level changed
	ecfg_evt_s evt_st; // Applied event state

	// Field extract helper, used for the multi-bit fields other than the unit number
	function automatic logic [3:0] fld(input logic [31:0] d, input int lsb);
		fld = d[lsb +: 4];
	endfunction

	// Decode helper: is the address one of ours
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == ADDR_CFG) || (a == ADDR_EVT) || (a == ADDR_COMM) ||
			(a == ADDR_ACT) || (a == ADDR_STAT);
	endfunction

	assign two_units = (i_evt_units >= 2'h2);
	assign evt_fit = (i_evt_units != 2'h0);
	assign opt_ok = (evt_fit || i_comm_unit) && (sec_r <= SEC_OPT_MAX);
	assign wr_go = i_psel && i_penable && pready_r && i_pwrite;
	assign lvl_sw = (md_r == MD_RUN) && !i_other_mode && (i_level <= LEVEL_MAX) &&
		(i_level != level_r);

	// ****************************************************************
	// Sub-blocks
	// ****************************************************************
	ecfg_key_hold #(
		.HOLD_CYC(HOLD_CYC)
	) u_key (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_key(i_mode_key),
		.o_held(held)
	);

	ecfg_evt_map u_evt (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_evt(i_evt),
		.i_sel(sel_r),
		.i_msp(msp_r),
		.i_two_units(two_units),
		.i_rsp_en(rsp_en_r),
		.i_comm_unit(i_comm_unit),
		.i_block(menu_r || opt_r || i_other_mode),
		.o_state(evt_st)
	);

	// ****************************************************************
	// Mode entry
	// ****************************************************************

	// Menu after a full hold; a second hold on the option item enters
	always_comb begin
		md_nxt = md_r;
		case (md_r)
			MD_RUN: begin
				if (held) md_nxt = MD_MENU;
			end
			MD_MENU: begin
				if (held && i_pick_option && opt_ok) begin
					md_nxt = MD_OPTION;
				end else if (held && !i_pick_option) begin
					md_nxt = MD_RUN; // Another item was taken
				end
			end
			MD_OPTION: begin
				if (!opt_ok) begin
					md_nxt = MD_RUN; // Unit pulled or security raised
				end else if (held) begin
					md_nxt = MD_MENU;
				end
			end
			default: begin
				md_nxt = MD_RUN;
			end
		endcase
		menu_nxt = (md_nxt == MD_MENU);
		opt_nxt = (md_nxt == MD_OPTION);
	end

	// Mode registers
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			md_r <= MD_RUN;
			menu_r <= 1'b0;
			opt_r <= 1'b0;
			level_r <= 2'h0;
		end else begin
			md_r <= md_nxt;
			menu_r <= menu_nxt;
			opt_r <= opt_nxt;
			level_r <= i_level;
		end
	end

	// ****************************************************************
	// Settings
	// ****************************************************************

	// Bad values keep the old field; fields for absent units are refused
	always_comb begin
		msp_nxt = msp_r;
		rsp_en_nxt = rsp_en_r;
		sec_nxt = sec_r;
		sel_nxt = sel_r;
		pend_nxt = pend_r;
		act_nxt = act_r;
		if (init_r) begin
			// Defaults depend on the fitted units, caught after release
			sel_nxt = {4{FN_NONE}};
			if (two_units) sel_nxt[3] = FN_RUN_HALT;
		end else if (wr_go) begin
			case (i_paddr)
				ADDR_CFG: begin
					if (evt_fit && 2'(fld(i_pwdata, CFG_MSP_LSB)) <= MSP_MAX) begin
						msp_nxt = 2'(fld(i_pwdata, CFG_MSP_LSB));
					end
					rsp_en_nxt = i_pwdata[CFG_RSP_BIT];
					sec_nxt = 2'(fld(i_pwdata, CFG_SEC_LSB));
				end
				ADDR_EVT: begin
					for (int i = 0; i < 4; i++) begin
						if (evt_fit && (two_units || i >= 2) &&
							3'(fld(i_pwdata, i * EVT_PITCH)) <= FN_SP_SRC) begin
							sel_nxt[i] = 3'(fld(i_pwdata, i * EVT_PITCH));
						end
					end
				end
				ADDR_COMM: begin
					if (i_comm_unit) begin
						pend_nxt.stop2 = i_pwdata[COMM_STOP_BIT];
						pend_nxt.len8 = i_pwdata[COMM_LEN_BIT];
						if (2'(fld(i_pwdata, COMM_PAR_LSB)) <= PAR_ODD) begin
							pend_nxt.parity = 2'(fld(i_pwdata, COMM_PAR_LSB));
						end
						if (3'(fld(i_pwdata, COMM_BAUD_LSB)) <= BAUD_MAX) begin
							pend_nxt.baud = 3'(fld(i_pwdata, COMM_BAUD_LSB));
						end
						if (i_pwdata[COMM_UNIT_LSB +: 7] <= UNIT_MAX) begin
							pend_nxt.unit = i_pwdata[COMM_UNIT_LSB +: 7];
						end
					end
				end
				default: begin
					// Read-only or unmapped: nothing stored
				end
			endcase
		end
		// Written values wait for a level switch; power-up loads the reset frame from pend_r
		if (init_r || lvl_sw) act_nxt = pend_r;
	end

	// Settings registers
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			msp_r <= MSP_RST;
			rsp_en_r <= 1'b0;
			sec_r <= SEC_RST;
			sel_r <= {4{FN_NONE}};
			pend_r <= COMM_RST;
			act_r <= COMM_RST;
			init_r <= 1'b1;
		end else begin
			msp_r <= msp_nxt;
			rsp_en_r <= rsp_en_nxt;
			sec_r <= sec_nxt;
			sel_r <= sel_nxt;
			pend_r <= pend_nxt;
			act_r <= act_nxt;
			init_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Register bus
	// ****************************************************************

	// One wait state: the answer is set up in the first access cycle
	always_comb begin
		pready_nxt = i_psel && i_penable && !pready_r;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		if (pready_nxt) begin
			pslverr_nxt = !mapped(i_paddr);
			prdata_nxt = 32'h0000_0000;
			case (i_paddr)
				ADDR_CFG: begin
					prdata_nxt[CFG_MSP_LSB +: 2] = msp_r;
					prdata_nxt[CFG_RSP_BIT] = rsp_en_r;
					prdata_nxt[CFG_SEC_LSB +: 2] = sec_r;
				end
				ADDR_EVT: begin
					for (int i = 0; i < 4; i++) begin
						prdata_nxt[i * EVT_PITCH +: 3] = sel_r[i];
					end
				end
				ADDR_COMM: begin
					prdata_nxt[14:0] = {pend_r.unit, 1'b0, pend_r.baud, pend_r.parity,
						pend_r.len8, pend_r.stop2};
				end
				ADDR_ACT: begin
					prdata_nxt[14:0] = {act_r.unit, 1'b0, act_r.baud, act_r.parity,
						act_r.len8, act_r.stop2};
				end
				ADDR_STAT: begin
					prdata_nxt[10:0] = {i_evt_units, opt_ok, opt_r, menu_r, evt_st};
				end
				default: begin
					prdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	// Bus answer registers
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_pready = pready_r;
	assign o_prdata = prdata_r;
	assign o_pslverr = pslverr_r;
	assign o_comm = act_r;
	assign o_evt = evt_st;
	assign o_menu_shown = menu_r;
	assign o_option_mode = opt_r;

endmodule
`default_nettype wire

// *** verif/ecfg_checker.sv ***
// Port-level assertions for the option configuration block
`timescale 1ns/100ps
`default_nettype none
module ecfg_checker
	import ecfg_pkg::*;
#(
	parameter int HOLD_CYC = KEY_HOLD_CYC // Key hold time in cycles
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_evt_units,
	input wire logic i_comm_unit,
	input wire logic i_mode_key,
	input wire logic i_other_mode,
	input wire logic [1:0] i_level,
	input wire ecfg_comm_s o_comm,
	input wire ecfg_evt_s o_evt,
	input wire logic o_menu_shown,
	input wire logic o_option_mode
);
	// ****
	// Helper logic
	// ****
	logic [7:0] run_r; // Consecutive key-high samples
	logic [7:0] run_nxt;
	logic blk; // Some mode that masks event functions
	assign blk = o_menu_shown | o_option_mode | i_other_mode;
	// Saturate so a long hold never wraps back through the figure
	always_comb begin
		run_nxt = 8'h00;
		if (i_mode_key) begin
			run_nxt = (run_r == 8'hFF) ? run_r : run_r + 8'h01;
		end
	end
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			run_r <= 8'h00;
		end else begin
			run_r <= run_nxt;
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// ****
	// Assertions
	// ****
	a_sp_units: assert property (i_evt_units != 2'h2 && $past(i_evt_units) != 2'h2
		|-> $stable(o_evt.sp_idx)) else $error("set point moved without two units");
	a_remote_comm: assert property (!i_comm_unit && !$past(i_comm_unit)
		|-> !o_evt.remote) else $error("remote without comm unit");
	a_mask_freeze: assert property (blk ##1 blk
		|=> $stable({o_evt.halt, o_evt.manual})) else $error("masked event acted");
	a_comm_hold: assert property (!$stable(o_comm) |-> $past(i_level) != $past(i_level, 2)
		|| $past(i_level, 2) != $past(i_level, 3)) else $error("frame changed without level");
	a_frame_range: assert property (o_comm.baud <= BAUD_MAX && o_comm.unit <= UNIT_MAX
		&& o_comm.parity <= PAR_ODD) else $error("frame field out of range");
	a_opt_entry: assert property ($rose(o_option_mode)
		|-> $past(o_menu_shown) && (i_evt_units != 2'h0 || i_comm_unit))
		else $error("option entered without menu or unit");
	a_opt_leave: assert property (o_option_mode && i_evt_units == 2'h0 && !i_comm_unit
		|-> ##[1:3] !o_option_mode) else $error("option kept without unit");
	a_menu_hold: assert property ($rose(o_menu_shown)
		|-> $past(run_r) == 8'(HOLD_CYC)) else $error("menu without full key hold");
	a_mode_excl: assert property (!(o_menu_shown && o_option_mode))
		else $error("menu and option together");
endmodule
bind ecfg_top ecfg_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
	.i_evt_units(i_evt_units), .i_comm_unit(i_comm_unit), .i_mode_key(i_mode_key),
	.i_other_mode(i_other_mode), .i_level(i_level), .o_comm(o_comm), .o_evt(o_evt),
	.o_menu_shown(o_menu_shown), .o_option_mode(o_option_mode));
`default_nettype wire

// *** verif/ecfg_host_model.sv ***
// Host computer model: reports whether its own frame agrees with the controller
`timescale 1ns/100ps
`default_nettype none
module ecfg_host_model
	import ecfg_pkg::*;
(
	input wire logic i_mclk,
	input wire ecfg_comm_s i_dev, // Frame in force at the controller
	input wire ecfg_comm_s i_own, // Frame the host is set up for
	output logic o_match
);
	logic match_nxt;
	// Unit number is not part of the frame, so it is left out
	always_comb begin
		match_nxt = i_dev.stop2 == i_own.stop2 && i_dev.len8 == i_own.len8
			&& i_dev.parity == i_own.parity && i_dev.baud == i_own.baud;
	end
	always_ff @(posedge i_mclk) begin
		o_match <= match_nxt;
	end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the option configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench
	import ecfg_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pw = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic prdy, perr, menu, opt, match;
	logic [3:0] evt = 4'h0;
	logic [1:0] units = 2'h2;
	logic [1:0] lvl = 2'h0;
	logic comm_u = 1'b1;
	logic key = 1'b0;
	logic pick = 1'b0;
	logic oth = 1'b0;
	ecfg_comm_s comm;
	ecfg_comm_s want = COMM_RST; // Host frame, starts at the defaults
	ecfg_evt_s ev_o;
	int fails = 0;
	int n_tests = 0;
	always #2 clk = ~clk;
	ecfg_top #(.HOLD_CYC(8)) uut (.i_mclk(clk), .i_rst_b(rst_b), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd), .o_pready(prdy),
		.o_prdata(prd), .o_pslverr(perr), .i_evt(evt), .i_evt_units(units),
		.i_comm_unit(comm_u), .i_mode_key(key), .i_pick_option(pick), .i_other_mode(oth),
		.i_level(lvl), .o_comm(comm), .o_evt(ev_o), .o_menu_shown(menu),
		.o_option_mode(opt));
	ecfg_host_model hm (.i_mclk(clk), .i_dev(comm), .i_own(want), .o_match(match));
	// ****
	// Tasks
	// ****
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// One APB transfer; on a read d is the expected data
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pw <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			final_report();
		end
		chk("pslverr", {31'h0, ee}, {31'h0, perr});
		if (w == 1'b0) begin
			chk("prdata", d, prd);
		end
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Event outputs answer one edge after the contacts are taken
	task ev(input logic [3:0] v, input logic [5:0] e);
		@(posedge clk);
		evt <= v;
		repeat (2) @(posedge clk);
		chk("o_evt", {26'h0, e}, {26'h0, ev_o});
	endtask
	task hold(input int n);
		@(posedge clk);
		key <= 1'b1;
		repeat (n) @(posedge clk);
		key <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task rst(input logic [1:0] u);
		@(posedge clk);
		units <= u;
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	task endt(input string s);
		$display("test %s done", s);
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		rst(2'h2);
		xf(0, ADDR_CFG, 32'h12, 0);
		xf(0, ADDR_EVT, 32'h1000, 0);
		xf(0, ADDR_COMM, 32'h35, 0);
		xf(0, ADDR_ACT, 32'h35, 0);
		xf(0, 8'h20, 32'h0, 1);
		xf(1, 8'h40, 32'h1, 1);
		chk("match", 32'h1, {31'h0, match});
		endt("reset");
		xf(1, ADDR_COMM, 32'h634A, 0);
		xf(0, ADDR_COMM, 32'h634A, 0);
		xf(1, ADDR_COMM, 32'h6435, 0);
		xf(0, ADDR_COMM, 32'h6335, 0);
		xf(1, ADDR_ACT, 32'h0, 0);
		xf(0, ADDR_ACT, 32'h35, 0);
		lvl <= 2'h1;
		repeat (4) @(posedge clk);
		chk("o_comm", 32'h31B5, {18'h0, comm});
		xf(0, ADDR_ACT, 32'h6335, 0);
		xf(1, ADDR_COMM, 32'h634A, 0);
		lvl <= 2'h2;
		repeat (4) @(posedge clk);
		chk("match", 32'h0, {31'h0, match});
		want <= '{unit: 7'h00, baud: 3'h4, parity: 2'h2, len8: 1'b1, stop2: 1'b0};
		repeat (2) @(posedge clk);
		chk("match", 32'h1, {31'h0, match});
		endt("comm");
		xf(1, ADDR_CFG, 32'h14, 0);
		xf(1, ADDR_EVT, 32'h4321, 0);
		ev(4'hF, 6'h0F);
		ev(4'h0, 6'h00);
		xf(1, ADDR_CFG, 32'h16, 0);
		ev(4'h3, 6'h30);
		xf(1, ADDR_CFG, 32'h15, 0);
		ev(4'h1, 6'h10);
		xf(1, ADDR_CFG, 32'h14, 0);
		ev(4'h2, 6'h14);
		xf(1, ADDR_CFG, 32'h10, 0);
		ev(4'h8, 6'h10);
		comm_u <= 1'b0;
		ev(4'h2, 6'h10);
		comm_u <= 1'b1;
		endt("events");
		hold(7);
		chk("menu", 32'h0, {31'h0, menu});
		hold(8);
		chk("menu", 32'h1, {31'h0, menu});
		ev(4'h1, 6'h10);
		hold(8);
		chk("menu", 32'h0, {31'h0, menu});
		ev(4'h1, 6'h18);
		oth <= 1'b1;
		ev(4'h4, 6'h18);
		oth <= 1'b0;
		ev(4'h4, 6'h12);
		endt("menu");
		hold(8);
		pick <= 1'b1;
		hold(8);
		chk("option", 32'h1, {31'h0, opt});
		units <= 2'h0;
		comm_u <= 1'b0;
		repeat (4) @(posedge clk);
		chk("option", 32'h0, {31'h0, opt});
		units <= 2'h2;
		comm_u <= 1'b1;
		xf(1, ADDR_CFG, 32'h20, 0);
		hold(8);
		hold(8);
		chk("option", 32'h0, {31'h0, opt});
		chk("menu", 32'h1, {31'h0, menu});
		endt("option");
		rst(2'h1);
		xf(0, ADDR_EVT, 32'h0, 0);
		xf(1, ADDR_EVT, 32'h1111, 0);
		xf(0, ADDR_EVT, 32'h1100, 0);
		endt("one unit");
		final_report();
	end
endmodule
`default_nettype wire
